// File: rtl/pist_consts.vh
`ifndef PIST_CONSTS_VH
`define PIST_CONSTS_VH

// Bus geometry
`define PIST_AW              8
`define PIST_DW              32

// Register indices and byte addresses (byte address = index times four)
`define PIST_IDX_CTRL_ONE    8'h12
`define PIST_IDX_STS_TWO     8'h13
`define PIST_ADDR_CTRL_ONE   8'h48
`define PIST_ADDR_STS_TWO    8'h4c
`define PIST_ADDR_IRQ_STS    8'h80
`define PIST_ADDR_IRQ_MASK   8'h84

// Status and control two: latched flags high, enables low
`define PIST_FLAG_MSB        15
`define PIST_FLAG_LSB        8
`define PIST_EN2_MSB         7
`define PIST_EN2_LSB         0
`define PIST_BIT_EEE_FLAG    15
`define PIST_BIT_AN_FLAG     14
`define PIST_BIT_PAGE_FLAG   13
`define PIST_BIT_LB_FLAG     12
`define PIST_BIT_MDIX_FLAG   11
`define PIST_BIT_SLEEP_FLAG  10
`define PIST_BIT_POLWOL_FLAG 9
`define PIST_BIT_JAB_FLAG    8
`define PIST_BIT_EEE_EN      7
`define PIST_BIT_AN_EN       6
`define PIST_BIT_PAGE_EN     5
`define PIST_BIT_LB_EN       4
`define PIST_BIT_MDIX_EN     3
`define PIST_BIT_SLEEP_EN    2
`define PIST_BIT_POLWOL_EN   1
`define PIST_BIT_JAB_EN      0

// Control one: the two counter half-full enables
`define PIST_BIT_FC_HF_EN    1
`define PIST_BIT_RXE_HF_EN   0

// Unified source numbering used by flags, irq status and mask
`define PIST_NSRC            10
`define PIST_NSRC_TWO        8

// Reset values
`define PIST_RST_EN2         8'h00
`define PIST_RST_EN1         2'h0
`define PIST_RST_SRC         10'h000

// Bus responses
`define PIST_RESP_OKAY       2'h0
`define PIST_RESP_SLVERR     2'h2

`endif

// File: rtl/pist_axil_slave.v
`timescale 1ns/1ps
`include "pist_consts.vh"

// AXI4-Lite front end: one write and one read in flight, turned into
// single-cycle strobes toward the register file.
module pist_axil_slave (
    input  wire                 sys_clk,
    input  wire                 srst,
    input  wire [`PIST_AW-1:0]  s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [`PIST_DW-1:0]  s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [`PIST_AW-1:0]  s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [`PIST_DW-1:0]  s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    output wire                 wr_en,
    output wire [`PIST_AW-1:0]  wr_addr,
    output wire [`PIST_DW-1:0]  wr_data,
    output wire [3:0]           wr_strb,
    input  wire                 wr_ok,
    output wire                 rd_en,
    output wire [`PIST_AW-1:0]  rd_addr,
    input  wire [`PIST_DW-1:0]  rd_data,
    input  wire                 rd_ok
);

    reg                 aw_got_q;
    reg                 w_got_q;
    reg                 rd_pend_q;
    reg [`PIST_AW-1:0]  wr_addr_q;
    reg [`PIST_DW-1:0]  wr_data_q;
    reg [3:0]           wr_strb_q;
    reg [`PIST_AW-1:0]  rd_addr_q;

    // Write fires once both halves are in; bvalid blocks a second one
    assign wr_en   = aw_got_q & w_got_q & ~s_axi_bvalid;
    assign wr_addr = wr_addr_q;
    assign wr_data = wr_data_q;
    assign wr_strb = wr_strb_q;
    assign rd_en   = rd_pend_q;
    assign rd_addr = rd_addr_q;

    // Write channels, taken in either order
    always @(posedge sys_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PIST_RESP_OKAY;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            wr_addr_q     <= {`PIST_AW{1'b0}};
            wr_data_q     <= {`PIST_DW{1'b0}};
            wr_strb_q     <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q      <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr_q     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q      <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data_q    <= s_axi_wdata;
                wr_strb_q    <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `PIST_RESP_OKAY : `PIST_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: data sampled in the strobe cycle, so read side
    // effects and the returned value refer to the same instant
    always @(posedge sys_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `PIST_RESP_OKAY;
            s_axi_rdata   <= {`PIST_DW{1'b0}};
            rd_pend_q     <= 1'b0;
            rd_addr_q     <= {`PIST_AW{1'b0}};
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                rd_addr_q     <= s_axi_araddr;
                rd_pend_q     <= 1'b1;
            end
            if (rd_pend_q) begin
                rd_pend_q    <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_data : {`PIST_DW{1'b0}};
                s_axi_rresp  <= rd_ok ? `PIST_RESP_OKAY : `PIST_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// File: rtl/pist_top.v
`timescale 1ns/1ps
`include "pist_consts.vh"

// Overview of operation
// - Control one bit 1 is a read-write enable, reset zero, for the false carrier counter half-full interrupt.
// - Control one bit 0 is a read-write enable, reset zero, for the receive error counter half-full interrupt.
// - Status two bit 15 is a read-only latched flag set on an EEE error, reset zero.
// - Bit 14 is a read-only latched flag set on an auto-negotiation error event.
// - Bit 13 is a read-only latched flag set when an auto-negotiation page arrives.
// - Bit 12 is a read-only latched flag set on loopback FIFO overflow or underflow.
// - Bit 11 is a read-only latched flag set when the MDI/MDIX crossover state changes.
// - Bit 10 is a read-only latched flag set on a sleep mode event.
// - Bit 9 is a shared latched flag set on a polarity change or a wake packet.
// - Bit 8 is a read-only latched flag set when jabber is detected.
// - Enables at bits 7 to 4, reset zero, gate EEE error, AN error, page and loopback FIFO sources.
// - Enables at bits 3 and 2, reset zero, gate MDI/MDIX change and sleep mode sources.
// - Enable bit 1, reset zero, gates the shared polarity or wake packet source.
// - Enable bit 0, reset zero, gates the jabber source.
module pist_top (
    input  wire                 sys_clk,
    input  wire                 srst,
    input  wire [`PIST_AW-1:0]  s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output wire                 s_axi_awready,
    input  wire [`PIST_DW-1:0]  s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output wire                 s_axi_wready,
    output wire [1:0]           s_axi_bresp,
    output wire                 s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [`PIST_AW-1:0]  s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output wire                 s_axi_arready,
    output wire [`PIST_DW-1:0]  s_axi_rdata,
    output wire [1:0]           s_axi_rresp,
    output wire                 s_axi_rvalid,
    input  wire                 s_axi_rready,
    input  wire                 evt_eee_err,
    input  wire                 evt_an_err,
    input  wire                 evt_page_rx,
    input  wire                 evt_loopback_fifo,
    input  wire                 evt_mdix_change,
    input  wire                 evt_sleep,
    input  wire                 evt_polarity_change,
    input  wire                 evt_wol_packet,
    input  wire                 evt_jabber,
    input  wire                 evt_false_carrier_half,
    input  wire                 evt_receive_error_half,
    output reg                  int_req_q,
    output reg                  irq_q
);

    // Strobes from the bus front end
    wire                  wr_en;
    wire [`PIST_AW-1:0]   wr_addr;
    wire [`PIST_DW-1:0]   wr_data;
    wire [3:0]            wr_strb;
    wire                  rd_en;
    wire [`PIST_AW-1:0]   rd_addr;
    reg  [`PIST_DW-1:0]   rd_data;
    reg                   rd_ok;
    reg                   wr_ok;

    // Register state
    reg  [7:0]            en2_q;
    reg  [1:0]            en1_q;
    reg  [`PIST_NSRC-1:0] flag_q;
    reg  [`PIST_NSRC-1:0] irq_sts_q;
    reg  [`PIST_NSRC-1:0] irq_mask_q;

    // Next values and per-source helpers
    wire [`PIST_NSRC-1:0] src_evt;
    wire [`PIST_NSRC-1:0] en_all;
    wire [`PIST_NSRC-1:0] rd_clr;
    wire [`PIST_NSRC-1:0] w1c;
    wire [`PIST_NSRC-1:0] mask_wr;
    wire [`PIST_NSRC-1:0] flag_d;
    wire [`PIST_NSRC-1:0] irq_sts_d;
    wire [`PIST_NSRC-1:0] irq_mask_d;

    wire                  wr_one;
    wire                  wr_two;
    wire                  wr_sts;
    wire                  wr_mask;
    wire                  rd_one;
    wire                  rd_two;

    pist_axil_slave u_bus (
        .sys_clk       (sys_clk),
        .srst          (srst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // Address decode of the strobes
    assign wr_one  = wr_en & (wr_addr == `PIST_ADDR_CTRL_ONE);
    assign wr_two  = wr_en & (wr_addr == `PIST_ADDR_STS_TWO);
    assign wr_sts  = wr_en & (wr_addr == `PIST_ADDR_IRQ_STS);
    assign wr_mask = wr_en & (wr_addr == `PIST_ADDR_IRQ_MASK);
    assign rd_one  = rd_en & (rd_addr == `PIST_ADDR_CTRL_ONE);
    assign rd_two  = rd_en & (rd_addr == `PIST_ADDR_STS_TWO);

    // Source vector, high index first in the same order as status two
    assign src_evt = {evt_eee_err,
                      evt_an_err,
                      evt_page_rx,
                      evt_loopback_fifo,
                      evt_mdix_change,
                      evt_sleep,
                      evt_polarity_change | evt_wol_packet,
                      evt_jabber,
                      evt_false_carrier_half,
                      evt_receive_error_half};

    // Enables laid out to match the sources
    assign en_all = {en2_q, en1_q};

    // Reading a register clears only the flags that live in it
    assign rd_clr = {{`PIST_NSRC_TWO{rd_two}}, {2{rd_one}}};

    // Per-source flag, irq status and mask next-state logic
    genvar gi;
    generate
        for (gi = 0; gi < `PIST_NSRC; gi = gi + 1) begin : g_src
            // Bits 0..7 sit in byte lane 0, the rest in lane 1
            assign w1c[gi]     = wr_sts & wr_strb[gi / 8] & wr_data[gi];
            assign mask_wr[gi] = wr_mask & wr_strb[gi / 8];
            // Latched high: a new event in the read cycle wins
            assign flag_d[gi]  = src_evt[gi] |
                                 (flag_q[gi] & ~rd_clr[gi]);
            // Sticky status, set only by enabled sources; set beats W1C
            assign irq_sts_d[gi] = (src_evt[gi] & en_all[gi]) |
                                   (irq_sts_q[gi] & ~w1c[gi]);
            assign irq_mask_d[gi] = mask_wr[gi] ? wr_data[gi]
                                                : irq_mask_q[gi];
        end
    endgenerate

    // Latched flags of both registers
    always @(posedge sys_clk) begin
        if (srst) begin
            flag_q <= `PIST_RST_SRC;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Enables of status two, software owned
    always @(posedge sys_clk) begin
        if (srst) begin
            en2_q <= `PIST_RST_EN2;
        end else if (wr_two && wr_strb[0]) begin
            // Flag bits of the write are ignored, they are read-only
            en2_q <= wr_data[`PIST_EN2_MSB:`PIST_EN2_LSB];
        end
    end

    // Counter half-full enables of control one
    always @(posedge sys_clk) begin
        if (srst) begin
            en1_q <= `PIST_RST_EN1;
        end else if (wr_one && wr_strb[0]) begin
            en1_q[`PIST_BIT_FC_HF_EN]  <= wr_data[`PIST_BIT_FC_HF_EN];
            en1_q[`PIST_BIT_RXE_HF_EN] <= wr_data[`PIST_BIT_RXE_HF_EN];
        end
    end

    // Sticky interrupt status and its mask
    always @(posedge sys_clk) begin
        if (srst) begin
            irq_sts_q  <= `PIST_RST_SRC;
            irq_mask_q <= `PIST_RST_SRC;
        end else begin
            irq_sts_q  <= irq_sts_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // Outputs from next values so both lag the event by one edge only
    always @(posedge sys_clk) begin
        if (srst) begin
            int_req_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            int_req_q <= |(flag_d & en_all);
            irq_q     <= |(irq_sts_d & irq_mask_d);
        end
    end

    // Read mux; reserved bits read zero
    always @* begin
        rd_data = {`PIST_DW{1'b0}};
        rd_ok   = 1'b1;
        case (rd_addr)
            `PIST_ADDR_CTRL_ONE: begin
                rd_data[1:0] = en1_q;
            end
            `PIST_ADDR_STS_TWO: begin
                rd_data[`PIST_FLAG_MSB:`PIST_FLAG_LSB] =
                    flag_q[`PIST_NSRC-1:2];
                rd_data[`PIST_EN2_MSB:`PIST_EN2_LSB] = en2_q;
            end
            `PIST_ADDR_IRQ_STS: begin
                rd_data[`PIST_NSRC-1:0] = irq_sts_q;
            end
            `PIST_ADDR_IRQ_MASK: begin
                rd_data[`PIST_NSRC-1:0] = irq_mask_q;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // Write decode answer; unmapped addresses get SLVERR
    always @* begin
        case (wr_addr)
            `PIST_ADDR_CTRL_ONE: wr_ok = 1'b1;
            `PIST_ADDR_STS_TWO:  wr_ok = 1'b1;
            `PIST_ADDR_IRQ_STS:  wr_ok = 1'b1;
            `PIST_ADDR_IRQ_MASK: wr_ok = 1'b1;
            default:             wr_ok = 1'b0;
        endcase
    end

endmodule

// File: test/pist_checker.sv
`timescale 1ns/1ps
`include "pist_consts.vh"

// Watches the top ports only; bound from the bench top
module pist_checker (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        evt_eee_err,
    input wire logic        evt_an_err,
    input wire logic        evt_page_rx,
    input wire logic        evt_loopback_fifo,
    input wire logic        evt_mdix_change,
    input wire logic        evt_sleep,
    input wire logic        evt_polarity_change,
    input wire logic        evt_wol_packet,
    input wire logic        evt_jabber,
    input wire logic        evt_false_carrier_half,
    input wire logic        evt_receive_error_half,
    input wire logic        int_req_q,
    input wire logic        irq_q
);
    // Any source firing; request outputs may only rise behind one of these or a bus answer
    wire logic any_evt = |{evt_eee_err, evt_an_err, evt_page_rx,
        evt_loopback_fifo, evt_mdix_change, evt_sleep, evt_polarity_change,
        evt_wol_packet, evt_jabber, evt_false_carrier_half,
        evt_receive_error_half};
    wire logic bus_done = s_axi_rvalid || s_axi_bvalid;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Bus steps: address phase taken, then the answer
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_wr_answer: assert property (s_wr_take |=> !s_axi_awready
        ##1 s_axi_bvalid) else $error("write answer late");
    a_rd_answer: assert property (s_rd_take |=> !s_axi_arready
        ##1 s_axi_rvalid) else $error("read answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data not held");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
    a_rd_error: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
        s_axi_rresp == `PIST_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("bad read error answer");
    // Must also hold across reset, so it is not disabled by it
    a_rst_quiet: assert property (disable iff (1'b0) srst |=>
        !int_req_q && !irq_q && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not cleared by reset");
    a_req_fall: assert property ($fell(int_req_q) |-> bus_done
        || $past(bus_done) || $past(srst)) else $error("request dropped");
    a_req_rise: assert property ($rose(int_req_q) |-> $past(any_evt)
        || bus_done || $past(bus_done)) else $error("request without cause");
    a_irq_rise: assert property ($rose(irq_q) |-> $past(any_evt)
        || s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq no cause");
    a_irq_fall: assert property ($fell(irq_q) |-> s_axi_bvalid
        || $past(s_axi_bvalid) || $past(srst)) else $error("irq dropped");
endmodule

// File: test/pist_host.sv
`timescale 1ns/1ps

// Management host: AXI4-Lite master, one access at a time
module pist_host (
    input wire logic         sys_clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input wire logic         s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input wire logic         s_axi_wready,
    input wire logic [1:0]   s_axi_bresp,
    input wire logic         s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic [31:0]  s_axi_rdata,
    input wire logic [1:0]   s_axi_rresp,
    input wire logic         s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} <= 45'h0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} <= 10'h0;
        {s_axi_arvalid, s_axi_rready} <= 2'h0;
    end

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge sys_clk);
            if (aw_p && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge sys_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk); // Gap so the next access never re-drives here
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule

// File: test/phy_interrupt_status_two_tb_top.sv
`timescale 1ns/1ps
`include "pist_consts.vh"

module phy_interrupt_status_two_tb_top;
    logic        sys_clk;
    logic        srst;
    logic [10:0] ev;
    wire  [7:0]  awaddr, araddr;
    wire  [31:0] wdata, rdata;
    wire  [3:0]  wstrb;
    wire  [1:0]  bresp, rresp;
    wire         awvalid, awready, wvalid, wready, bvalid, bready;
    wire         arvalid, arready, rvalid, rready, int_req_q, irq_q;
    int          fail_count;
    int          n_tests;
    int          k;
    logic [9:0]  lat, ists, mask, en; // Model: flags, irq status, mask, enables
    logic [31:0] rdv, rs;
    logic [1:0]  rsp;
    logic [7:0]  amap [5] = '{8'h48, 8'h4c, 8'h80, 8'h84, 8'h50};

    pist_top i_dut (.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .evt_eee_err(ev[10]), .evt_an_err(ev[9]),
        .evt_page_rx(ev[8]), .evt_loopback_fifo(ev[7]),
        .evt_mdix_change(ev[6]), .evt_sleep(ev[5]),
        .evt_polarity_change(ev[4]), .evt_wol_packet(ev[3]),
        .evt_jabber(ev[2]), .evt_false_carrier_half(ev[1]),
        .evt_receive_error_half(ev[0]), .int_req_q(int_req_q),
        .irq_q(irq_q));

    pist_host i_host (.sys_clk(sys_clk), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Requests follow pending enabled flags and unmasked irq status
    task automatic chk_out;
        chk("int_req_q", {31'h0, |(lat & en)}, {31'h0, int_req_q});
        chk("irq_q", {31'h0, |(ists & mask)}, {31'h0, irq_q});
    endtask

    task automatic rdc(input logic [7:0] a);
        logic [31:0] e;
        logic [1:0]  er;
        e = 32'h0;
        er = `PIST_RESP_OKAY;
        case (a)
            `PIST_ADDR_CTRL_ONE: e = {30'h0, en[1:0]};
            `PIST_ADDR_STS_TWO: e = {16'h0, lat[9:2], en[9:2]};
            `PIST_ADDR_IRQ_STS: e = {22'h0, ists};
            `PIST_ADDR_IRQ_MASK: e = {22'h0, mask};
            default: er = `PIST_RESP_SLVERR;
        endcase
        i_host.rd(a, rdv, rsp);
        chk("rdata", e, rdv);
        chk("rresp", {30'h0, er}, {30'h0, rsp});
        // Reading clears that register's latched flags
        if (a == `PIST_ADDR_CTRL_ONE) lat[1:0] = 2'h0;
        if (a == `PIST_ADDR_STS_TWO) lat[9:2] = 8'h0;
        chk_out;
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] er;
        er = `PIST_RESP_OKAY;
        case (a)
            `PIST_ADDR_CTRL_ONE: en[1:0] = d[1:0];
            `PIST_ADDR_STS_TWO: en[9:2] = d[7:0];
            `PIST_ADDR_IRQ_STS: ists = ists & ~d[9:0];
            `PIST_ADDR_IRQ_MASK: mask = d[9:0];
            default: er = `PIST_RESP_SLVERR;
        endcase
        i_host.wr(a, d, rsp);
        chk("bresp", {30'h0, er}, {30'h0, rsp});
        chk_out;
    endtask

    // One-cycle event burst; polarity and wake share one source
    task automatic pulse(input logic [10:0] e);
        logic [9:0] s;
        s = {e[10:5], e[4] | e[3], e[2:0]};
        ev <= e;
        @(posedge sys_clk);
        ev <= 11'h0;
        lat = lat | s;
        ists = ists | (s & en);
        @(posedge sys_clk);
        chk_out;
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(50 * 40000);
        fail_count++;
        print_verdict;
    end

    initial begin
        {lat, ists, mask, en} = 40'h0;
        srst = 1'b1;
        ev = 11'h0;
        rs = $urandom(99);
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        // Reset values, unmapped read and write
        for (k = 0; k < 5; k++) rdc(amap[k]);
        wrc(8'h50, 32'hffffffff);
        // Enables read back; flag bits ignore writes
        wrc(`PIST_ADDR_STS_TWO, $urandom());
        rdc(`PIST_ADDR_STS_TWO);
        wrc(`PIST_ADDR_CTRL_ONE, $urandom());
        rdc(`PIST_ADDR_CTRL_ONE);
        // Each source alone: all enabled first, then random gating
        for (k = 0; k < 33; k++) begin
            if (k == 0 || k >= 11) begin
                rs = (k == 0) ? 32'hffffffff : $urandom();
                wrc(`PIST_ADDR_STS_TWO, rs);
                wrc(`PIST_ADDR_CTRL_ONE, rs >> 8);
                wrc(`PIST_ADDR_IRQ_MASK, rs >> 12);
            end
            pulse(11'h1 << (k % 11));
            rdc(`PIST_ADDR_STS_TWO);
            rdc(`PIST_ADDR_CTRL_ONE);
            rdc(`PIST_ADDR_IRQ_STS);
            wrc(`PIST_ADDR_IRQ_STS, $urandom());
            rdc(`PIST_ADDR_IRQ_STS);
        end
        // Random bursts mixed with random accesses
        for (k = 0; k < 60; k++) begin
            pulse(11'($urandom()));
            rs = $urandom();
            if (rs[0]) rdc(amap[rs[3:1] % 5]);
            else wrc(amap[rs[3:1] % 5], $urandom());
        end
        print_verdict;
    end
endmodule

bind pist_top pist_checker i_chk (.sys_clk(sys_clk), .srst(srst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .evt_eee_err(evt_eee_err),
    .evt_an_err(evt_an_err), .evt_page_rx(evt_page_rx),
    .evt_loopback_fifo(evt_loopback_fifo),
    .evt_mdix_change(evt_mdix_change), .evt_sleep(evt_sleep),
    .evt_polarity_change(evt_polarity_change),
    .evt_wol_packet(evt_wol_packet), .evt_jabber(evt_jabber),
    .evt_false_carrier_half(evt_false_carrier_half),
    .evt_receive_error_half(evt_receive_error_half),
    .int_req_q(int_req_q), .irq_q(irq_q));
